// File: boot_recovery_watchdog.sv
// boot recovery supervisor: reset release, boot watchdog and recovery power cycle
//
// Behaviour
// RULE1: one pin is the active-high boot-ready input, another the fallback-hold output.
// RULE2: after power-up completes, release system reset, then start the boot watchdog.
// RULE3: no boot-ready before timeout (7 s or 20 s) enters recovery.
// RULE4: recovery switches regulators off, pulls system reset and fallback-hold low.
// RULE5: after an off interval of 100 ms or 250 ms, re-run power-up.
// RULE6: fallback-hold stays low until system reset is next released high.
// RULE7: watchdog armed only after reset release and only while recovery is enabled.
// RULE8: host clears recovery enable before power-save that could outlast the timeout.
// RULE9: pins are inputs or open-drain only, each with selectable polarity; the system reset pin here is fixed active-low with no polarity select.
// RULE10: system reset released after a selectable delay once all rails are valid.
// RULE11: boot-ready is synchronised; first high sample disarms watchdog for the cycle.
`timescale 1ns/1ps
`default_nettype none
`include "brw_params.svh"
module boot_recovery_watchdog
	import brw_pkg::*;
#(
	parameter logic [`BRW_CNT_W-1:0] TIMEOUT_SHORT_CYC = `BRW_CNT_W'(`BRW_TIMEOUT_SHORT_CYC),
	parameter logic [`BRW_CNT_W-1:0] TIMEOUT_LONG_CYC = `BRW_CNT_W'(`BRW_TIMEOUT_LONG_CYC),
	parameter logic [`BRW_CNT_W-1:0] OFF_SHORT_CYC = `BRW_CNT_W'(`BRW_OFF_SHORT_CYC),
	parameter logic [`BRW_CNT_W-1:0] OFF_LONG_CYC = `BRW_CNT_W'(`BRW_OFF_LONG_CYC),
	parameter logic [`BRW_CNT_W-1:0] REL_SHORT_CYC = `BRW_CNT_W'(`BRW_REL_SHORT_CYC),
	parameter logic [`BRW_CNT_W-1:0] REL_LONG_CYC = `BRW_CNT_W'(`BRW_REL_LONG_CYC)
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic seq_done,
	input wire logic rails_valid,
	input wire logic recovery_en,
	input wire logic timeout_sel,
	input wire logic off_interval_sel,
	input wire logic reset_release_delay_sel,
	input wire logic boot_ready_inv,
	input wire logic fallback_inv,
	input wire logic boot_ready_in,
	output logic fallback_pin_out,
	output logic fallback_pin_oe,
	output logic system_reset_n_out,
	output logic sys_reset_pin_out,
	output logic sys_reset_pin_oe,
	output logic regs_off,
	output logic seq_restart,
	output logic watchdog_armed
);
	localparam int W = `BRW_CNT_W;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// pin level seen from the logical level and its polarity setting
	function automatic logic pin_level(input logic logical, input logic inv);
		pin_level = logical ^ inv;
	endfunction : pin_level

	function automatic logic [W-1:0] pick(input logic sel, input logic [W-1:0] a, input logic [W-1:0] b);
		pick = sel ? b : a;
	endfunction : pick

	// ----------------------------------------
	// boot-ready synchroniser
	// ----------------------------------------
	logic br_meta_r;
	logic br_sync_r;
	logic boot_ready_s;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			br_meta_r <= 1'b0;
			br_sync_r <= 1'b0;
		end else if (clk_en) begin
			br_meta_r <= boot_ready_in; // [RULE11]
			br_sync_r <= br_meta_r;
		end
	end

	// polarity applied after the second stage only
	assign boot_ready_s = pin_level(br_sync_r, boot_ready_inv); // [RULE1] [RULE9]

	// ----------------------------------------
	// interval timer
	// ----------------------------------------
	brw_tmr_if #(.W(W)) tmr ();

	brw_timer #(.W(W)) u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.t(tmr.timer)
	);

	// ----------------------------------------
	// supervisor state machine
	// ----------------------------------------
	brw_state_t state_r;
	brw_state_t state_nxt;
	logic tmr_start;
	logic tmr_stop;
	logic [W-1:0] tmr_limit;

	assign tmr.start = tmr_start;
	assign tmr.stop = tmr_stop;
	assign tmr.limit = tmr_limit;

	always_comb begin
		state_nxt = state_r;
		tmr_start = 1'b0;
		tmr_stop = 1'b0;
		tmr_limit = pick(reset_release_delay_sel, REL_SHORT_CYC, REL_LONG_CYC);
		unique case (state_r)
			BRW_WAIT_SEQ: begin
				tmr_stop = 1'b1;
				if (seq_done) begin
					state_nxt = BRW_REL_DLY; // [RULE2]
					tmr_start = 1'b1;
				end
			end
			BRW_REL_DLY: begin
				// the delay restarts while any rail is out of regulation
				if (!rails_valid) begin
					tmr_start = 1'b1; // [RULE10]
				end else if (tmr.expired) begin
					state_nxt = BRW_WATCH; // [RULE10] [RULE2]
					tmr_start = 1'b1;
					tmr_limit = pick(timeout_sel, TIMEOUT_SHORT_CYC, TIMEOUT_LONG_CYC); // [RULE3]
				end
			end
			BRW_WATCH: begin
				tmr_limit = pick(timeout_sel, TIMEOUT_SHORT_CYC, TIMEOUT_LONG_CYC);
				if (!rails_valid) begin
					state_nxt = BRW_REL_DLY;
					tmr_start = 1'b1;
					tmr_limit = pick(reset_release_delay_sel, REL_SHORT_CYC, REL_LONG_CYC);
				end else if (boot_ready_s) begin
					state_nxt = BRW_RUN; // [RULE11]
					tmr_stop = 1'b1;
				end else if (!recovery_en) begin
					// held at its full count while disabled, so clearing the bit is always safe
					tmr_start = 1'b1; // [RULE7] [RULE8]
				end else if (tmr.expired) begin
					state_nxt = BRW_OFF; // [RULE3]
					tmr_start = 1'b1;
					tmr_limit = pick(off_interval_sel, OFF_SHORT_CYC, OFF_LONG_CYC); // [RULE5]
				end
			end
			BRW_RUN: begin
				tmr_stop = 1'b1;
				if (!rails_valid) begin
					state_nxt = BRW_REL_DLY;
					tmr_stop = 1'b0;
					tmr_start = 1'b1;
				end
			end
			BRW_OFF: begin
				tmr_limit = pick(off_interval_sel, OFF_SHORT_CYC, OFF_LONG_CYC);
				if (tmr.expired) begin
					state_nxt = BRW_WAIT_SEQ; // [RULE5]
				end
			end
			default: begin
				state_nxt = BRW_WAIT_SEQ;
				tmr_stop = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= brw_state_t'(`BRW_RST_STATE);
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// system reset output
	// ----------------------------------------
	logic sys_rst_n_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sys_rst_n_r <= 1'b0;
		end else if (clk_en) begin
			// low in recovery and whenever the watchdog is not yet reached
			sys_rst_n_r <= (state_nxt == BRW_WATCH) || (state_nxt == BRW_RUN); // [RULE2] [RULE4] [RULE10]
		end
	end

	assign system_reset_n_out = sys_rst_n_r;
	assign sys_reset_pin_out = 1'b0; // [RULE9]
	assign sys_reset_pin_oe = ~sys_rst_n_r; // [RULE9]

	// ----------------------------------------
	// fallback-hold output
	// ----------------------------------------
	logic fallback_hold_n_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fallback_hold_n_r <= 1'b1;
		end else if (clk_en) begin
			if (state_r == BRW_WATCH && state_nxt == BRW_OFF) begin
				fallback_hold_n_r <= 1'b0; // [RULE4]
			end else if (state_r == BRW_REL_DLY && state_nxt == BRW_WATCH) begin
				fallback_hold_n_r <= 1'b1; // [RULE6]
			end
		end
	end

	// open drain: the pad is only ever pulled low, a high level comes from the pull-up
	assign fallback_pin_out = 1'b0; // [RULE9]
	assign fallback_pin_oe = ~pin_level(fallback_hold_n_r, fallback_inv); // [RULE1] [RULE9]

	// ----------------------------------------
	// regulator and sequencer controls
	// ----------------------------------------
	logic regs_off_r;
	logic seq_restart_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regs_off_r <= 1'b0;
			seq_restart_r <= 1'b0;
		end else if (clk_en) begin
			regs_off_r <= (state_nxt == BRW_OFF); // [RULE4]
			seq_restart_r <= (state_r == BRW_OFF) && tmr.expired; // [RULE5]
		end
	end

	assign regs_off = regs_off_r;
	assign seq_restart = seq_restart_r;
	assign watchdog_armed = (state_r == BRW_WATCH) && recovery_en && tmr.running; // [RULE7]
endmodule : boot_recovery_watchdog
`default_nettype wire

// File: brw_params.svh
// constants for the boot recovery watchdog: timing figures and derived cycle counts
`ifndef BRW_PARAMS_SVH
`define BRW_PARAMS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define BRW_CLK_HZ 100000000

// ----------------------------------------
// timing figures in their own units
// ----------------------------------------
`define BRW_TIMEOUT_SHORT_S 7
`define BRW_TIMEOUT_LONG_S 20
`define BRW_OFF_SHORT_MS 100
`define BRW_OFF_LONG_MS 250
`define BRW_REL_SHORT_US 500
`define BRW_REL_LONG_US 100000

// ----------------------------------------
// derived cycle counts
// ----------------------------------------
`define BRW_TIMEOUT_SHORT_CYC (`BRW_TIMEOUT_SHORT_S * `BRW_CLK_HZ)
`define BRW_TIMEOUT_LONG_CYC (`BRW_TIMEOUT_LONG_S * `BRW_CLK_HZ)
`define BRW_OFF_SHORT_CYC (`BRW_OFF_SHORT_MS * (`BRW_CLK_HZ / 1000))
`define BRW_OFF_LONG_CYC (`BRW_OFF_LONG_MS * (`BRW_CLK_HZ / 1000))
`define BRW_REL_SHORT_CYC (`BRW_REL_SHORT_US * (`BRW_CLK_HZ / 1000000))
`define BRW_REL_LONG_CYC (`BRW_REL_LONG_US * (`BRW_CLK_HZ / 1000000))

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define BRW_CNT_W 32
`define BRW_RST_STATE 3'h0

`endif

// File: brw_pkg.sv
// types for the boot recovery watchdog
`default_nettype none
package brw_pkg;

	// ----------------------------------------
	// supervisor states
	// ----------------------------------------
	typedef enum logic [2:0] {
		BRW_WAIT_SEQ = 3'h0,
		BRW_REL_DLY = 3'h1,
		BRW_WATCH = 3'h2,
		BRW_RUN = 3'h3,
		BRW_OFF = 3'h4
	} brw_state_t;

endpackage : brw_pkg
`default_nettype wire

// File: brw_tmr_if.sv
// carrier between the supervisor and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface brw_tmr_if #(parameter int W = 32);
	logic start;
	logic stop;
	logic [W-1:0] limit;
	logic expired;
	logic running;

	modport ctrl (output start, output stop, output limit, input expired, input running);
	modport timer (input start, input stop, input limit, output expired, output running);
endinterface : brw_tmr_if
`default_nettype wire

// File: brw_timer.sv
// down-counting interval timer with a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module brw_timer #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	brw_tmr_if.timer t
);
	logic [W-1:0] cnt_r;
	logic run_r;
	logic expired_r;

	assign t.expired = expired_r;
	assign t.running = run_r;

	// ----------------------------------------
	// counter; start wins over stop
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			expired_r <= 1'b0;
		end else if (clk_en) begin
			expired_r <= 1'b0;
			if (t.start) begin
				cnt_r <= t.limit;
				run_r <= 1'b1;
			end else if (t.stop) begin
				run_r <= 1'b0;
			end else if (run_r) begin
				if (cnt_r <= W'(1)) begin
					run_r <= 1'b0;
					expired_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - W'(1);
				end
			end
		end
	end
endmodule : brw_timer
`default_nettype wire

// File: brw_sva.sv
// port assertions for the boot recovery watchdog
`timescale 1ns/1ps
`default_nettype none
module brw_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic rails_valid,
	input wire logic recovery_en,
	input wire logic fallback_inv,
	input wire logic fallback_pin_out,
	input wire logic fallback_pin_oe,
	input wire logic system_reset_n_out,
	input wire logic sys_reset_pin_out,
	input wire logic sys_reset_pin_oe,
	input wire logic regs_off,
	input wire logic seq_restart,
	input wire logic watchdog_armed
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic fb_low;
	assign fb_low = fallback_pin_oe != fallback_inv;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_no_high_drive: assert property (fallback_pin_out == 1'b0 && sys_reset_pin_out == 1'b0)
		else $error("pin driven high");
	a_reset_pin_oe: assert property (sys_reset_pin_oe == !system_reset_n_out)
		else $error("reset pin enable wrong");
	a_off_holds_low: assert property (regs_off |-> !system_reset_n_out && fb_low)
		else $error("off without reset and fallback low");
	a_fb_release: assert property ($fell(fb_low) |-> $rose(system_reset_n_out))
		else $error("fallback released apart from reset");
	a_armed_cause: assert property (watchdog_armed |-> system_reset_n_out && recovery_en)
		else $error("armed while reset or disabled");
	a_off_cause: assert property ($rose(regs_off) |-> $past(system_reset_n_out) && $past(recovery_en))
		else $error("recovery without release or enable");
	a_off_interval: assert property ($rose(regs_off) |=> regs_off [*8])
		else $error("off interval too short");
	a_restart_pulse: assert property ($rose(seq_restart) |-> !regs_off && $past(regs_off))
		else $error("restart pulse wrong");
	// a frozen clock enable may stretch the pulse, so only an enabled edge must end it
	a_restart_single: assert property (seq_restart && clk_en |=> !seq_restart)
		else $error("restart pulse too long");
	a_rails_hold: assert property (!rails_valid && clk_en |=> !system_reset_n_out)
		else $error("reset released with rails low");
	c_recovery: cover property ($rose(regs_off));
	c_release: cover property ($rose(system_reset_n_out));
	c_restart: cover property (seq_restart);
endmodule : brw_sva
bind boot_recovery_watchdog brw_sva u_sva (.clk, .reset_n, .clk_en, .rails_valid, .recovery_en, .fallback_inv,
	.fallback_pin_out, .fallback_pin_oe, .system_reset_n_out, .sys_reset_pin_out, .sys_reset_pin_oe,
	.regs_off, .seq_restart, .watchdog_armed);
`default_nettype wire

// File: brw_core_model.sv
// storage core model: sequencer done pulse and boot-ready pin
`timescale 1ns/1ps
`default_nettype none
module brw_core_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic system_reset_n_out,
	input wire logic seq_restart,
	input wire logic ready_inv,
	input wire logic [31:0] ready_dly,
	output logic seq_done,
	output logic boot_ready_pin
);
	int cnt_r;
	logic st_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= 1'b1;
			seq_done <= 1'b0;
			cnt_r <= 0;
		end else begin
			seq_done <= st_r;
			st_r <= seq_restart;
			cnt_r <= system_reset_n_out ? cnt_r + 1 : 0;
		end
	end
	// ready only once out of reset; delay 0 models a core that never boots
	assign boot_ready_pin = ((ready_dly != 0) && (cnt_r >= ready_dly)) ^ ready_inv;
endmodule : brw_core_model
`default_nettype wire

// File: test_boot_recovery_watchdog.sv
// self-checking bench for the boot recovery watchdog
`timescale 1ns/1ps
`default_nettype none
module test_boot_recovery_watchdog;
	localparam logic [31:0] TS = 32'hc8, TL = 32'h190, OS = 32'h32, OL = 32'h50, RS = 32'ha, RL = 32'h1e;
	logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, rails_valid = 1'b0, recovery_en = 1'b0;
	logic timeout_sel = 1'b0, off_interval_sel = 1'b0, reset_release_delay_sel = 1'b0;
	logic boot_ready_inv = 1'b0, fallback_inv = 1'b0, seq_done, boot_ready_in, rec;
	logic fallback_pin_out, fallback_pin_oe, system_reset_n_out, sys_reset_pin_out, sys_reset_pin_oe;
	logic regs_off, seq_restart, watchdog_armed;
	int ready_dly = 0, errors = 0, checked = 0, seed = 32'h8588dbdd, n, t, f, d;
	always #5 clk = ~clk;
	boot_recovery_watchdog #(.TIMEOUT_SHORT_CYC(TS), .TIMEOUT_LONG_CYC(TL), .OFF_SHORT_CYC(OS),
		.OFF_LONG_CYC(OL), .REL_SHORT_CYC(RS), .REL_LONG_CYC(RL)) DUT (.clk, .reset_n, .clk_en, .seq_done,
		.rails_valid, .recovery_en, .timeout_sel, .off_interval_sel, .reset_release_delay_sel,
		.boot_ready_inv, .fallback_inv, .boot_ready_in, .fallback_pin_out, .fallback_pin_oe,
		.system_reset_n_out, .sys_reset_pin_out, .sys_reset_pin_oe, .regs_off, .seq_restart, .watchdog_armed);
	brw_core_model core (.clk, .reset_n, .system_reset_n_out, .seq_restart, .ready_inv(boot_ready_inv),
		.ready_dly, .seq_done, .boot_ready_pin(boot_ready_in));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// which: 0 reset released, 1 regulators off, 2 restart pulse
	task automatic wait_for(input int which, input int lim, output int cnt);
		cnt = 0;
		while (cnt < lim && !(which == 0 ? system_reset_n_out === 1'b1 :
			which == 1 ? regs_off === 1'b1 : seq_restart === 1'b1)) begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask : wait_for
	task automatic end_sim;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			reset_n <= 1'b0;
			rails_valid <= 1'b0;
			{timeout_sel, off_interval_sel, reset_release_delay_sel, boot_ready_inv, fallback_inv} <= 5'($random(seed));
			recovery_en <= (i != 2); // host with power-save plans keeps it clear
			ready_dly <= (i == 1 || i == 4) ? 20 : 0;
			repeat (10) @(posedge clk);
			reset_n <= 1'b1;
			repeat ((i % 2) * 40) @(posedge clk);
			rails_valid <= 1'b1;
			#1;
			t = timeout_sel ? TL : TS;
			f = off_interval_sel ? OL : OS;
			d = reset_release_delay_sel ? RL : RS;
			rec = recovery_en && ready_dly == 0;
			wait_for(0, 200, n);
			check(n >= d && n <= d + 8, 1);
			check(fallback_pin_oe, fallback_inv);
			check({sys_reset_pin_oe, sys_reset_pin_out, fallback_pin_out}, 3'h0);
			check(watchdog_armed, recovery_en);
			// frozen cycles must not age the watchdog, so the timeout shifts by them
			@(posedge clk);
			clk_en <= 1'b0;
			repeat (5) @(posedge clk);
			clk_en <= 1'b1;
			#1;
			wait_for(1, t + 20, n);
			check(regs_off, rec);
			check(watchdog_armed, 1'b0);
			if (rec) begin
				check(n >= t && n <= t + 4, 1);
				check({system_reset_n_out, fallback_pin_oe}, {1'b0, !fallback_inv});
				ready_dly <= 20;
				wait_for(2, f + 20, n);
				check(n >= f && n <= f + 4, 1);
				check(fallback_pin_oe, !fallback_inv);
				wait_for(0, 200, n);
				check({system_reset_n_out, fallback_pin_oe}, {1'b1, fallback_inv});
				wait_for(1, t + 20, n);
				check(regs_off, 0);
			end
			$display("test %0d done", i);
		end
		end_sim();
	end
	// long enough for six worst-case runs with both intervals long
	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule : test_boot_recovery_watchdog
`default_nettype wire
